// ### common/adsq_cfg.svh
// adsq_cfg.svh - addresses, field positions, reset values and timing of the converter sequencer
`ifndef ADSQ_CFG_SVH
`define ADSQ_CFG_SVH
// register byte offsets
`define ADSQ_OFS_CTRL   4'h0
`define ADSQ_OFS_STAT   4'h4
`define ADSQ_OFS_RESULT 4'h8
`define ADSQ_OFS_PLL    4'hC
// control register fields
`define ADSQ_C_START    0
`define ADSQ_C_CAL      1
`define ADSQ_C_SINGLE   2
`define ADSQ_C_ICD      3
`define ADSQ_C_MAP      4
`define ADSQ_C_BUF      5
`define ADSQ_C_INCA     6
`define ADSQ_C_INCB     7
`define ADSQ_C_CRST     8
`define ADSQ_C_MASK     9
`define ADSQ_C_DLY      23:16
`define ADSQ_C_PTRA     26:24
`define ADSQ_C_PTRB     30:28
// status register fields
`define ADSQ_S_DONE     0
`define ADSQ_S_BUSY     1
`define ADSQ_S_QCNT     3:2
`define ADSQ_S_VALID    4
`define ADSQ_S_PLLREQ   5
// result register fields
`define ADSQ_R_A        9:0
`define ADSQ_R_B        25:16
// pll register field
`define ADSQ_P_SET      2:0
// reset values
`define ADSQ_DLY_RST    8'h00
`define ADSQ_PTR_RST    3'h0
`define ADSQ_PLL_RST    3'h0
// timing
`define ADSQ_CLK_HZ     64'd250000000
`define ADSQ_TB_HZ      64'd32768
`define ADSQ_TB_FRAC    24
`define ADSQ_PLL_BASE   8'd80
`define ADSQ_PLL_STEP   8'd4
`define ADSQ_CONV_SKIP  2'd2
`define ADSQ_LAST_IDX   3'd7
`define ADSQ_QUEUE_MAX  2'd2
`define ADSQ_FULL_SCALE 12'sd1023
`define ADSQ_UNUSED_CH  3'd3
`endif

// ### common/adsq_pkg.sv
// adsq_pkg - types shared by the converter sequencer
package adsq_pkg;
  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_WAIT_PLL = 3'b001,
    S_SYNC     = 3'b010,
    S_DELAY    = 3'b011,
    S_CONV     = 3'b100,
    S_WAIT     = 3'b101
  } adsq_state_type;
endpackage

// ### hdl/adsq_sequencer.sv
// adsq_sequencer - converter sequencer with wishbone register slave
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "adsq_cfg.svh"

// What this block does
// R1 - converter clock runs at two thirds of the pll rate and follows its setting
// R2 - a request with the pll off turns the pll on before converting
// R3 - a 32.768 kHz time base comes from the converter clock, constant over pll settings
// R4 - each conversion yields a ten-bit result
// R5 - eight channels chosen by a three-bit code
// R6 - map select 1 moves touch inputs to channels 4-7, channels 0-3 unused
// R7 - with buffer enable set, buffer is on only during conversions
// R8 - far over range gives full scale, far under gives near zero
// R9 - up to two pending requests are queued and run in turn
// R10 - series completion sets the done flag, a mask bit suppresses the interrupt
// R11 - a series starts on trigger pin rise or a written start bit
// R12 - start bit clears at series end; trigger rise shows it high meanwhile
// R13 - eight conversions unless map select 1 skips channels 0-3: one per channel, or pointer a channel eight times
// R14 - calibrate bit makes a calibration series, then clears and raises done
// R15 - software should calibrate once after a cold start
// R16 - conversion starts after sync plus 1 to 256 time base periods
// R17 - inter-conversion bit inserts the start delay between conversions too
// R18 - eight results are held for readout, not readable after calibration
// R19 - result read returns values indexed by pointer a and pointer b
// R20 - each pointer with auto-increment set advances after every result read
// R21 - self-clearing core reset clears core state, keeps settings and results
// R22 - software rewrites the settings after a core reset
// R23 - queued requests run in arrival order, second after first completes
module adsq_sequencer
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic             wb_ack_o,
  input  wire logic        conv_trigger_pin_i,
  input  wire logic        pll_active_i,
  output logic             pll_enable_o,
  output logic             core_start_o,
  output logic      [2:0]  core_chan_o,
  output logic             core_cal_o,
  output logic             core_reset_o,
  input  wire logic        core_done_i,
  input  wire logic [11:0] core_raw_i,
  output logic             touch_map_o,
  output logic             buf_en_o,
  output logic             conv_done_irq_o
);
  import adsq_pkg::*;

  // ****************************************
  // synchronisers for pin inputs
  // ****************************************
  logic [2:0] trig_sync_q;
  logic [1:0] pll_sync_q;

  // two flops before use; third stage only for edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig_sync_q <= 3'h0;
      pll_sync_q  <= 2'h0;
    end
    else
    begin
      trig_sync_q <= {trig_sync_q[1:0], conv_trigger_pin_i};
      pll_sync_q  <= {pll_sync_q[0], pll_active_i};
    end
  end

  wire trig_rise = trig_sync_q[1] & ~trig_sync_q[2]; // [R11]
  wire pll_on    = pll_sync_q[1];

  // ****************************************
  // register state
  // ****************************************
  logic             ack_q;
  logic [31:0]      dat_q;
  logic             cal_bit_q, single_q, icd_q, map_q, bufen_q, inca_q, incb_q, mask_q;
  logic [7:0]       dly_q;
  logic [2:0]       ptr_a_q, ptr_b_q, pll_set_q;
  logic             done_flag_q, valid_q;
  logic [1:0]       qcnt_q;
  adsq_state_type   state_q, state_d;
  logic [2:0]       idx_q;
  logic [8:0]       dly_cnt_q;
  logic             cur_cal_q, cur_single_q;
  logic [9:0]       res_q [8];
  logic [7:0]       pll_div_q;
  logic [1:0]       pll_ph_q;
  logic [`ADSQ_TB_FRAC:0] tb_acc_q;
  logic             core_start_q, core_cal_q, core_reset_q, pll_req_q, map_out_q, buf_q, irq_q;
  logic [2:0]       chan_q;

  // ****************************************
  // bus decode
  // ****************************************
  // ack one cycle after the strobe, never twice in a row
  wire hit      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr       = hit & wb_we_i;
  wire rd       = hit & ~wb_we_i;
  wire sel_ctrl = wb_adr_i == `ADSQ_OFS_CTRL;
  wire sel_stat = wb_adr_i == `ADSQ_OFS_STAT;
  wire sel_res  = wb_adr_i == `ADSQ_OFS_RESULT;
  wire sel_pll  = wb_adr_i == `ADSQ_OFS_PLL;
  wire wr_c0    = wr & sel_ctrl & wb_sel_i[0];
  wire wr_c1    = wr & sel_ctrl & wb_sel_i[1];
  wire wr_c2    = wr & sel_ctrl & wb_sel_i[2];
  wire wr_c3    = wr & sel_ctrl & wb_sel_i[3];
  wire rd_res   = rd & sel_res;

  // ****************************************
  // clocking: pll tick, converter tick, time base
  // ****************************************
  // pll period in system clocks shrinks as the setting rises
  wire [7:0] pll_per  = `ADSQ_PLL_BASE - (`ADSQ_PLL_STEP * {5'h00, pll_set_q});
  wire       pll_tick = pll_on & (pll_div_q == 8'h00);
  wire       conv_tick = pll_tick & (pll_ph_q != `ADSQ_CONV_SKIP); // two of every three [R1]

  // time base increment per converter tick, scaled so its rate stays fixed [R3]
  function automatic logic [`ADSQ_TB_FRAC-1:0] tb_inc(input logic [7:0] per);
    logic [63:0] num;
    num = (`ADSQ_TB_HZ << `ADSQ_TB_FRAC) * 64'd3 * {56'h0, per};
    return 24'(num / (64'd2 * `ADSQ_CLK_HZ));
  endfunction

  wire [`ADSQ_TB_FRAC-1:0] inc_now = tb_inc(pll_per);
  wire [`ADSQ_TB_FRAC:0]   tb_sum  = {1'b0, tb_acc_q[`ADSQ_TB_FRAC-1:0]} + {1'b0, inc_now};
  wire                     tb_tick = tb_acc_q[`ADSQ_TB_FRAC]; // one-cycle time base strobe
  wire                     crst    = wr_c1 & wb_dat_i[`ADSQ_C_CRST];

  // divider chain; core reset restarts the time base [R21]
  always_ff @(posedge clk_i)
  begin
    if (rst_i | crst)
    begin
      pll_div_q <= 8'h00;
      pll_ph_q  <= 2'h0;
      tb_acc_q  <= '0;
    end
    else
    begin
      pll_div_q <= (!pll_on || pll_div_q == 8'h00) ? pll_per - 8'h01 : pll_div_q - 8'h01; // [R1]
      pll_ph_q  <= pll_tick ? (pll_ph_q == `ADSQ_CONV_SKIP ? 2'h0 : pll_ph_q + 2'h1) : pll_ph_q;
      tb_acc_q  <= conv_tick ? tb_sum : {1'b0, tb_acc_q[`ADSQ_TB_FRAC-1:0]}; // [R3]
    end
  end

  // ****************************************
  // request queue
  // ****************************************
  wire soft_req = wr_c0 & wb_dat_i[`ADSQ_C_START];
  wire req      = soft_req | trig_rise; // [R11]
  wire launch   = (state_q == S_IDLE) & (qcnt_q != 2'h0);
  // a third request while two are pending is dropped unless a launch in the same cycle frees a slot [R9]
  wire q_add    = req & ((qcnt_q != `ADSQ_QUEUE_MAX) | launch);
  wire [1:0] qcnt_d = crst ? 2'h0 : qcnt_q + {1'b0, q_add} - {1'b0, launch}; // [R23]
  wire busy     = state_q != S_IDLE;
  wire start_rd = busy | (qcnt_q != 2'h0); // [R12]

  // ****************************************
  // sequencer
  // ****************************************
  wire [2:0] chan     = cur_single_q ? ptr_a_q : idx_q; // [R13]
  wire       unused   = map_q & (chan <= `ADSQ_UNUSED_CH); // [R6]
  wire       conv_end = (state_q == S_WAIT) & core_done_i;
  wire       last     = idx_q == `ADSQ_LAST_IDX;
  wire       ser_end  = conv_end & last;
  wire       cal_end  = ser_end & cur_cal_q;
  wire       skip_end = (state_q == S_CONV) & unused & last;
  wire       fin      = ser_end | skip_end;
  wire       step     = (conv_end | ((state_q == S_CONV) & unused)) & ~last;
  wire signed [11:0] raw = core_raw_i;
  // saturate the raw core word to the ten-bit range [R8]
  wire [9:0] clamped  = raw < 12'sd0 ? 10'h000 : (raw > `ADSQ_FULL_SCALE ? 10'h3FF : raw[9:0]); // [R4]

  // next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:     if (launch) state_d = S_WAIT_PLL;
      S_WAIT_PLL: if (pll_on) state_d = S_SYNC; // [R2]
      S_SYNC:     if (tb_tick) state_d = S_DELAY; // [R16]
      S_DELAY:    if (tb_tick && dly_cnt_q == 9'h000) state_d = S_CONV;
      // inter-conversion delay realigns to the time base first, so it never shrinks below one period
      S_CONV:     state_d = unused ? (last ? S_IDLE : (icd_q ? S_SYNC : S_CONV)) : S_WAIT;
      S_WAIT:     if (core_done_i) state_d = last ? S_IDLE : (icd_q ? S_SYNC : S_CONV); // [R17]
      default:    state_d = S_IDLE;
    endcase
    if (crst)
      state_d = S_IDLE; // [R21]
  end

  // sequencer registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q      <= S_IDLE;
      qcnt_q       <= 2'h0;
      idx_q        <= 3'h0;
      dly_cnt_q    <= 9'h000;
      cur_cal_q    <= 1'b0;
      cur_single_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      qcnt_q  <= qcnt_d; // [R9]
      if (launch)
      begin
        cur_cal_q    <= cal_bit_q; // [R14]
        cur_single_q <= single_q;
      end
      idx_q <= launch ? 3'h0 : (step ? idx_q + 3'h1 : idx_q); // eight per series [R13]
      // load n, count n+1 periods: zero periods cannot happen [R16]
      if (state_d == S_DELAY && state_q != S_DELAY)
        dly_cnt_q <= {1'b0, dly_q};
      else if (state_q == S_DELAY && tb_tick)
        dly_cnt_q <= dly_cnt_q - 9'h001;
    end
  end

  // partial series land in staging; readable results change only when a series completes [R18]
  logic [9:0] stage_q [8];
  wire  [9:0] res_new = unused ? 10'h000 : clamped;
  wire        st_we   = ((conv_end && !cur_cal_q) || ((state_q == S_CONV) && unused)) && !crst;
  wire        commit  = fin && !cur_cal_q && !crst;

  // one staging and one result word per index; a cut series leaves old results intact [R21]
  for (genvar gi = 0; gi < 8; gi++)
  begin : g_res
    always_ff @(posedge clk_i)
    begin
      if (st_we && idx_q == 3'(gi))
        stage_q[gi] <= res_new;
      if (commit)
        res_q[gi] <= (st_we && idx_q == 3'(gi)) ? res_new : stage_q[gi];
    end
  end

  // ****************************************
  // control and status registers
  // ****************************************
  wire       done_d = fin | (done_flag_q & ~(wr & sel_stat & wb_sel_i[0] & wb_dat_i[`ADSQ_S_DONE])); // [R10]
  wire       mask_d = wr_c1 ? wb_dat_i[`ADSQ_C_MASK] : mask_q;
  wire [2:0] ptr_a_inc = ptr_a_q + 3'h1;
  wire [2:0] ptr_b_inc = ptr_b_q + 3'h1;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cal_bit_q   <= 1'b0;
      single_q    <= 1'b0;
      icd_q       <= 1'b0;
      map_q       <= 1'b0;
      bufen_q     <= 1'b0;
      inca_q      <= 1'b0;
      incb_q      <= 1'b0;
      mask_q      <= 1'b0;
      dly_q       <= `ADSQ_DLY_RST;
      ptr_a_q     <= `ADSQ_PTR_RST;
      ptr_b_q     <= `ADSQ_PTR_RST;
      pll_set_q   <= `ADSQ_PLL_RST;
      done_flag_q <= 1'b0;
      valid_q     <= 1'b0;
    end
    else
    begin
      // software write wins over the end-of-calibration clear
      if (wr_c0)
        cal_bit_q <= wb_dat_i[`ADSQ_C_CAL];
      else if (cal_end)
        cal_bit_q <= 1'b0; // [R14]
      if (wr_c0)
      begin
        single_q <= wb_dat_i[`ADSQ_C_SINGLE];
        icd_q    <= wb_dat_i[`ADSQ_C_ICD];
        map_q    <= wb_dat_i[`ADSQ_C_MAP];
        bufen_q  <= wb_dat_i[`ADSQ_C_BUF];
        inca_q   <= wb_dat_i[`ADSQ_C_INCA];
        incb_q   <= wb_dat_i[`ADSQ_C_INCB];
      end
      mask_q <= mask_d;
      if (wr_c2)
        dly_q <= wb_dat_i[`ADSQ_C_DLY];
      // pointers with auto-increment set advance after each result read [R20]
      if (wr_c3)
      begin
        ptr_a_q <= wb_dat_i[`ADSQ_C_PTRA];
        ptr_b_q <= wb_dat_i[`ADSQ_C_PTRB];
      end
      else if (rd_res)
      begin
        ptr_a_q <= inca_q ? ptr_a_inc : ptr_a_q;
        ptr_b_q <= incb_q ? ptr_b_inc : ptr_b_q;
      end
      if (wr && sel_pll && wb_sel_i[0])
        pll_set_q <= wb_dat_i[`ADSQ_P_SET]; // [R1]
      done_flag_q <= done_d; // set wins over clear [R10]
      if (fin)
        valid_q <= ~cur_cal_q; // [R18]
    end
  end

  // ****************************************
  // read mux and bus answer
  // ****************************************
  wire [31:0] ctrl_rd = {1'b0, ptr_b_q, 1'b0, ptr_a_q, dly_q, 6'h00, mask_q, 1'b0,
                         incb_q, inca_q, bufen_q, map_q, icd_q, single_q, cal_bit_q, start_rd};
  wire [31:0] stat_rd = {26'h000_0000, pll_req_q, valid_q, qcnt_q, busy, done_flag_q};
  wire [9:0]  fa      = valid_q ? res_q[ptr_a_q] : 10'h000; // [R19]
  wire [9:0]  fb      = valid_q ? res_q[ptr_b_q] : 10'h000;
  wire [31:0] res_rd  = {6'h00, fb, 6'h00, fa};
  wire [31:0] pll_rd  = {29'h0000_0000, pll_set_q};
  wire [31:0] rd_mux  = sel_ctrl ? ctrl_rd : sel_stat ? stat_rd : sel_res ? res_rd : sel_pll ? pll_rd : 32'h0000_0000;

  // unmapped offsets still ack, reading zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= hit;
      dat_q <= rd ? rd_mux : dat_q;
    end
  end

  // ****************************************
  // registered outputs to core and system
  // ****************************************
  wire conv_d = (state_d == S_CONV) & ~(map_q & ((cur_single_q ? ptr_a_q : (step ? idx_q + 3'h1 : idx_q))
                 <= `ADSQ_UNUSED_CH));
  wire [2:0] chan_d = state_d == S_CONV ? (cur_single_q ? ptr_a_q : (step ? idx_q + 3'h1 : idx_q)) : chan_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      core_start_q <= 1'b0;
      chan_q       <= 3'h0;
      core_cal_q   <= 1'b0;
      core_reset_q <= 1'b0;
      pll_req_q    <= 1'b0;
      map_out_q    <= 1'b0;
      buf_q        <= 1'b0;
      irq_q        <= 1'b0;
    end
    else
    begin
      core_start_q <= conv_d & (state_q != S_CONV || unused || conv_end || state_q == S_DELAY);
      chan_q       <= chan_d; // [R5]
      core_cal_q   <= (state_d != S_IDLE) & (launch ? cal_bit_q : cur_cal_q); // [R14]
      core_reset_q <= crst; // [R21]
      pll_req_q    <= (state_d != S_IDLE) | (qcnt_d != 2'h0); // [R2]
      map_out_q    <= wr_c0 ? wb_dat_i[`ADSQ_C_MAP] : map_q; // [R6]
      buf_q        <= bufen_q & (state_d == S_CONV || state_d == S_WAIT); // [R7]
      irq_q        <= done_d & ~mask_d; // [R10]
    end
  end

  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = dat_q;
  assign pll_enable_o    = pll_req_q;
  assign core_start_o    = core_start_q;
  assign core_chan_o     = chan_q;
  assign core_cal_o      = core_cal_q;
  assign core_reset_o    = core_reset_q;
  assign touch_map_o     = map_out_q;
  assign buf_en_o        = buf_q;
  assign conv_done_irq_o = irq_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_bus_answer;
    s_req |=> s_ack_once;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus request not acked once");

  property p_done_irq;
    fin |=> done_flag_q && (conv_done_irq_o == !mask_q);
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("series end did not raise done"); // [R10]

  property p_queue;
    qcnt_q <= `ADSQ_QUEUE_MAX;
  endproperty
  a_queue: assert property (p_queue) else $error("queue holds more than two"); // [R9]

  property p_pll_req;
    (state_q == S_WAIT_PLL && !crst) |=> pll_enable_o;
  endproperty
  a_pll_req: assert property (p_pll_req) else $error("pll not requested while waiting"); // [R2]

  property p_buf_idle;
    (state_q == S_IDLE && !launch) |=> !buf_en_o;
  endproperty
  a_buf_idle: assert property (p_buf_idle) else $error("buffer on outside conversion"); // [R7]

  property p_autoinc;
    (rd_res && inca_q) |=> ptr_a_q == 3'($past(ptr_a_q) + 3'h1);
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("pointer a did not advance"); // [R20]

  property p_cal_invalid;
    cal_end |=> !valid_q && !core_cal_o;
  endproperty
  a_cal_invalid: assert property (p_cal_invalid) else $error("results valid after calibration"); // [R18]

  property p_core_reset;
    crst |=> state_q == S_IDLE && qcnt_q == 2'h0 && core_reset_o ##1 !core_reset_o;
  endproperty
  a_core_reset: assert property (p_core_reset) else $error("core reset did not clear sequencer"); // [R21]

  property p_min_delay;
    (state_q == S_SYNC && tb_tick && !crst) |=> state_q == S_DELAY;
  endproperty
  a_min_delay: assert property (p_min_delay) else $error("conversion skipped start delay"); // [R16]

endmodule
`default_nettype wire

// ### verif/adsq_core_model.sv
// adsq_core_model - converter core and switcher pll stand-in for the sequencer bench
`timescale 1ns/1ns
`default_nettype none
module adsq_core_model
(
  input  wire logic        clk_i,
  input  wire logic        pll_enable_i,
  input  wire logic        start_i,
  input  wire logic [2:0]  chan_i,
  input  wire logic        reset_i,
  output logic             pll_active_o,
  output logic             done_o,
  output logic      [11:0] raw_o
);
  int unsigned wait_q = 0;
  int unsigned pll_q  = 0;
  logic [2:0]  idx_q  = 3'h0;
  logic [2:0]  ch_q   = 3'h0;

  // raw core value per channel and conversion index; ch0 over range, ch1 under range
  function automatic logic [11:0] raw_val(input logic [2:0] ch, input logic [2:0] k);
    raw_val = (ch == 3'h0) ? 12'h5ff : (ch == 3'h1) ? 12'hf80 : {2'b00, ch, 4'h0, k};
  endfunction

  // pll lock delay, then random conversion latency; raw bus toggles outside done
  initial
  begin
    pll_active_o = 1'b0;
    done_o       = 1'b0;
    raw_o        = 12'h000;
  end
  always @(posedge clk_i)
  begin
    done_o       <= 1'b0;
    raw_o        <= ~raw_o;
    pll_q        <= pll_enable_i ? pll_q + 1 : 0;
    pll_active_o <= pll_enable_i && (pll_q > 20);
    if (reset_i)
      idx_q <= 3'h0;
    if (start_i)
    begin
      wait_q <= 3 + $urandom_range(30);
      ch_q   <= chan_i;
    end
    else if (wait_q == 1)
    begin
      done_o <= 1'b1;
      raw_o  <= raw_val(ch_q, idx_q);
      idx_q  <= idx_q + 3'h1;
      wait_q <= 0;
    end
    else if (wait_q != 0)
      wait_q <= wait_q - 1;
  end
endmodule
`default_nettype wire

// ### verif/adsq_sequencer_tb.sv
// adsq_sequencer_tb - self-checking bench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
`include "adsq_cfg.svh"
module adsq_sequencer_tb;
  import adsq_pkg::*;
  typedef struct { logic [31:0] d; logic [31:0] m; } adsq_exp_type;
  logic        clk_i, rst_i, wb_we_i, wb_stb_i, wb_cyc_i, trig, wb_ack_o, pll_act, pll_en;
  logic        c_start, c_cal, c_rst, c_done, t_map, buf_en, irq, buf_seen, rst_seen;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, wb_dat_o, q;
  logic [2:0]  c_chan, ra, rb;
  logic [11:0] c_raw;
  adsq_exp_type rq[$];
  logic [2:0]  cq[$];
  int          n_errors = 0;
  int          n_checks = 0;
  int unsigned cyc_n = 0;
  int unsigned t_last = 0;
  int unsigned gap = 0;

  // ****************************************
  // clock, instances
  // ****************************************
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  adsq_sequencer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(sel), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
    .conv_trigger_pin_i(trig), .pll_active_i(pll_act), .pll_enable_o(pll_en), .core_start_o(c_start),
    .core_chan_o(c_chan), .core_cal_o(c_cal), .core_reset_o(c_rst), .core_done_i(c_done),
    .core_raw_i(c_raw), .touch_map_o(t_map), .buf_en_o(buf_en), .conv_done_irq_o(irq));
  adsq_core_model u_core (.clk_i(clk_i), .pll_enable_i(pll_en), .start_i(c_start), .chan_i(c_chan),
    .reset_i(c_rst), .pll_active_o(pll_act), .done_o(c_done), .raw_o(c_raw));

  // ****************************************
  // tasks
  // ****************************************
  task automatic fail(input string s);
    n_errors++;
    $display("[FAIL] %0t %s", $time, s);
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_checks++;
    if (got !== exp) fail(s);
  endtask
  task automatic cmp_read(input adsq_exp_type e);
    n_checks++;
    if ((wb_dat_o & e.m) !== (e.d & e.m)) fail("register read mismatch");
  endtask
  // classic single cycle; read expectations are queued for the monitor
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    adr      <= a;
    wdat     <= d;
    if (!w && m != 0) rq.push_back('{d, m});
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wait_start;
    int k;
    for (k = 0; k < 20000 && c_start !== 1'b1; k++) @(posedge clk_i);
    #1;
  endtask
  // poll status until done, not busy and queue empty
  task automatic wait_idle;
    int k;
    for (k = 0; k < 30000; k++)
    begin
      wb(1'b0, `ADSQ_OFS_STAT, 0, 0);
      if (q[3:0] === 4'h1) break;
    end
  endtask
  // stored result: core value clamped to ten bits
  function automatic logic [9:0] er(input logic [2:0] ch);
    logic [11:0] v;
    v = u_core.raw_val(ch, ch);
    er = v[11] ? 10'h000 : (v > 12'h3ff) ? 10'h3ff : v[9:0];
  endfunction
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // monitors and watchdog
  // ****************************************
  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1 && !wb_we_i && rq.size() > 0) cmp_read(rq.pop_front());
    if (c_start === 1'b1)
    begin
      cmp_val(pll_act, 1, "conversion with pll off");
      gap = cyc_n - t_last;
      t_last = cyc_n;
      if (c_cal !== 1'b1 && cq.size() > 0) cmp_val(c_chan, cq.pop_front(), "channel order");
    end
    if (buf_en === 1'b1) buf_seen = 1'b1;
    if (c_rst === 1'b1) rst_seen = 1'b1;
    if (buf_en === 1'b1 && pll_en !== 1'b1) fail("buffer on while idle");
  end
  initial
  begin
    repeat (99000) @(posedge clk_i);
    fail("timeout");
    final_report();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {rst_i, wb_we_i, wb_stb_i, wb_cyc_i, trig, buf_seen, rst_seen} = 7'b1000000;
    {adr, sel, wdat} = {4'h0, 4'hf, 32'h0000_0000};
    void'($urandom(32'h192f_ea2a));
    ra = 3'($urandom_range(7));
    rb = 3'($urandom_range(7));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `ADSQ_OFS_CTRL, 0, '1);
    wb(1'b0, `ADSQ_OFS_STAT, 0, '1);
    wb(1'b0, 4'h2, 0, '1);
    wb(1'b1, `ADSQ_OFS_PLL, {29'h0, rb}, 0);
    wb(1'b0, `ADSQ_OFS_PLL, {29'h0, rb}, 32'h7);
    for (int i = 0; i < 16; i++) cq.push_back(3'(i));
    t_last = cyc_n;
    wb(1'b1, `ADSQ_OFS_CTRL, 32'h4000_00e1, 0);
    @(posedge clk_i) trig <= 1'b1;
    repeat (4) @(posedge clk_i);
    trig <= 1'b0;
    wb(1'b0, `ADSQ_OFS_CTRL, 1, 1);
    wait_start();
    cmp_val(gap >= 7500 && gap <= 15400, 1, "start delay");
    wait_idle();
    cmp_val(cq.size(), 0, "queued series count");
    cmp_val({irq, buf_seen}, 2'b11, "done irq or buffer");
    wb(1'b0, `ADSQ_OFS_STAT, 32'h11, 32'h1f);
    wb(1'b0, `ADSQ_OFS_CTRL, 0, 1);
    for (int i = 0; i < 4; i++)
      wb(1'b0, `ADSQ_OFS_RESULT, {6'h0, er(3'(i + 4)), 6'h0, er(3'(i))}, 32'h03ff_03ff);
    wb(1'b0, `ADSQ_OFS_CTRL, 32'h0400_0000, 32'h7700_0000);
    wb(1'b1, `ADSQ_OFS_CTRL, {1'b0, rb, 1'b0, ra, 24'h00_0210}, 0);
    repeat (3) @(posedge clk_i);
    cmp_val({t_map, irq}, 2'b10, "map or masked irq");
    wb(1'b1, `ADSQ_OFS_CTRL, {1'b0, rb, 1'b0, ra, 24'h00_0000}, 0);
    repeat (3) @(posedge clk_i);
    cmp_val({t_map, irq}, 2'b01, "map or unmasked irq");
    wb(1'b1, `ADSQ_OFS_STAT, 1, 0);
    repeat (3) @(posedge clk_i);
    cmp_val(irq, 0, "irq after clear");
    repeat (2) wb(1'b0, `ADSQ_OFS_RESULT, {6'h0, er(rb), 6'h0, er(ra)}, 32'h03ff_03ff);
    // single channel with inter-conversion delay, cut short by a core reset
    cq.push_back(ra);
    cq.push_back(ra);
    wb(1'b1, `ADSQ_OFS_CTRL, {5'h0, ra, 24'h00_000d}, 0);
    wait_start();
    wait_start();
    cmp_val(gap >= 7500 && gap <= 15400, 1, "inter-conversion delay");
    wb(1'b1, `ADSQ_OFS_CTRL, {5'h0, ra, 24'h00_0100}, 0);
    repeat (10) @(posedge clk_i);
    cmp_val(rst_seen, 1, "core reset pulse");
    wb(1'b0, `ADSQ_OFS_STAT, 32'h10, 32'h1e);
    wb(1'b0, `ADSQ_OFS_CTRL, {5'h0, ra, 24'h00_0000}, 32'h0700_0100);
    wb(1'b0, `ADSQ_OFS_RESULT, {6'h0, er(0), 6'h0, er(ra)}, 32'h03ff_03ff);
    // settings rewritten, then the calibration series
    wb(1'b1, `ADSQ_OFS_CTRL, 32'h0000_0003, 0);
    wait_idle();
    cmp_val(irq, 1, "irq after calibration");
    wb(1'b0, `ADSQ_OFS_CTRL, 0, 32'h3);
    wb(1'b0, `ADSQ_OFS_STAT, 32'h01, 32'h13);
    wb(1'b0, `ADSQ_OFS_RESULT, 0, '1);
    repeat (4) @(posedge clk_i);
    final_report();
  end
endmodule
`default_nettype wire
